// ---- rtl/ctrc_regs.svh ----
// Constants for the converter timebase and rate control block
// How it works
// - One synthesizer timebase drives both the input and output converters, always faster than the sample rate.
// - A backplane 10 MHz reference may be selected so that several modules share one timebase.
// - Input rates fall into four regions (2k-54k, 54k-108k, 108k-216k, 216k-432k), output regions at half those bounds.
// - The timebase runs 512k-13.824M in region 0, 6.912M-13.824M in regions 1 and 2, 13.824M-27.648M in region 3.
// - With both paths running, the path set first fixes the other path's region, and a conflicting request is refused.
// - With both paths in use, the shared trigger has no effect until both paths are configured.
// - Input pipeline latency is 12, 7, 5 and 5 samples for regions 0 to 3.
// - Output pipeline latency is 43.4, 87.5 and 176.8 samples for regions 0 to 2.
// - Three calibration banks exist; bank 0 holds factory constants, is the default and is never overwritten.
// - Auto-calibration results are stored only into the assigned user bank 1 or 2.
// - A nonvolatile boot-bank choice is kept until changed, and boot loads that bank or bank 0 without a choice.
// - Offset compensation runs only when the input rate changes region, lasting 6.2, 2.6, 1.3 or 0.65 s.
// - With both paths enabled, a trigger is valid only once both paths are ready for it.
`ifndef CTRC_REGS_SVH
`define CTRC_REGS_SVH
`define CTRC_CLK_KHZ 200000
`define CTRC_REF_KHZ 10000
`define CTRC_REF_MISS (2 * `CTRC_CLK_KHZ / `CTRC_REF_KHZ)
`define CTRC_AI_B1 19'h0d2f0
`define CTRC_AI_B2 19'h1a5e0
`define CTRC_AI_B3 19'h34bc0
`define CTRC_AO_B1 19'h06978
`define CTRC_AO_B2 19'h0d2f0
`define CTRC_AO_B3 19'h1a5e0
`define CTRC_SH_R0 5'h08
`define CTRC_SH_R1 5'h07
`define CTRC_SH_R23 5'h06
`define CTRC_AI_DLY_R0 4'hc
`define CTRC_AI_DLY_R1 4'h7
`define CTRC_AI_DLY_R23 4'h5
`define CTRC_AO_DLY_R0 11'h1b2
`define CTRC_AO_DLY_R1 11'h36b
`define CTRC_AO_DLY_R2 11'h6e8
`define CTRC_COMP_MS0 6200
`define CTRC_COMP_MS1 2600
`define CTRC_COMP_MS2 1300
`define CTRC_COMP_MS3 650
`define CTRC_CYC_PER_MS (`CTRC_CLK_KHZ)
`define CTRC_BANK_FACTORY 2'h0
`define CTRC_BANK_USER1 2'h1
`define CTRC_BANK_USER2 2'h2
`endif

// ---- rtl/ctrc_pkg.sv ----
// Types for the converter timebase and rate control block
package ctrc_pkg;
  typedef logic [1:0] ctrc_region_type;
  typedef enum logic [2:0] {
    CTRC_ST_BOOT = 3'b001,
    CTRC_ST_LOAD = 3'b010,
    CTRC_ST_RUN = 3'b100
  } ctrc_state_type;
  typedef struct packed {
    logic [3:0] ai_samples;
    logic [10:0] ao_tenths;
  } ctrc_delay_type;
  typedef struct packed {
    logic req;
    logic [1:0] bank;
  } ctrc_bank_cmd_type;
endpackage

// ---- rtl/ctrc_top.sv ----
// Converter timebase, rate region, trigger gate and calibration bank control
`timescale 1ns/1ps
`include "ctrc_regs.svh"
module ctrc_top #(
  parameter int RATE_W = 19,
  parameter int FREQ_W = 25,
  parameter logic [31:0] COMP_CYC0 = 32'(`CTRC_COMP_MS0 * `CTRC_CYC_PER_MS),
  parameter logic [31:0] COMP_CYC1 = 32'(`CTRC_COMP_MS1 * `CTRC_CYC_PER_MS),
  parameter logic [31:0] COMP_CYC2 = 32'(`CTRC_COMP_MS2 * `CTRC_CYC_PER_MS),
  parameter logic [31:0] COMP_CYC3 = 32'(`CTRC_COMP_MS3 * `CTRC_CYC_PER_MS)
) (
  input wire logic I_CLK, // 200 MHz clock
  input wire logic I_RESET_N, // Synchronous reset, active low
  input wire logic I_CE, // Clock enable, freezes all state when low
  input wire logic I_REF_EXT_EN, // Request backplane reference
  input wire logic I_REF_10M, // Backplane 10 MHz reference, sampled
  input wire logic I_AI_EN, // Input path enabled
  input wire logic I_AO_EN, // Output path enabled
  input wire logic I_AI_CFG_WR, // Input rate write strobe
  input wire logic [RATE_W-1:0] I_AI_RATE, // Input sample rate in Hz
  input wire logic I_AO_CFG_WR, // Output rate write strobe
  input wire logic [RATE_W-1:0] I_AO_RATE, // Output update rate in Hz
  input wire logic I_TRIG, // Shared trigger event pulse
  input wire ctrc_pkg::ctrc_bank_cmd_type I_CAL_STORE, // Auto-cal store request and bank
  input wire ctrc_pkg::ctrc_bank_cmd_type I_BOOT_SET, // Boot bank assignment
  input wire ctrc_pkg::ctrc_bank_cmd_type I_NV_BOOT, // Stored boot choice, req means valid
  output logic O_REF_EXT, // Synthesizer follows backplane reference
  output logic [FREQ_W-1:0] O_SYNTH_FREQ, // Synthesizer timebase frequency in Hz
  output logic O_SYNTH_LOAD, // Pulse: program the synthesizer
  output ctrc_pkg::ctrc_region_type O_REGION, // Active region index, from the last accepted input or output rate
  output ctrc_pkg::ctrc_delay_type O_DELAY, // Pipeline latencies
  output logic O_AI_READY, // Input path configured
  output logic O_AO_READY, // Output path configured
  output logic O_CFG_REFUSED, // Pulse: conflicting rate refused
  output logic O_COMP_BUSY, // Offset compensation in progress
  output logic O_TRIG_OUT, // Pulse: accepted trigger
  output logic O_TRIG_REFUSED, // Pulse: trigger ignored
  output ctrc_pkg::ctrc_bank_cmd_type O_CAL_WR, // Pulse: store constants to bank
  output logic O_CAL_REFUSED, // Pulse: store to bank refused
  output ctrc_pkg::ctrc_bank_cmd_type O_NV_BOOT_WR, // Pulse: write boot choice to storage
  output ctrc_pkg::ctrc_bank_cmd_type O_LOAD // Pulse: load constants from bank
);

  // Region of an input sample rate
  function automatic ctrc_pkg::ctrc_region_type ai_region(input logic [RATE_W-1:0] r);
    if (r < `CTRC_AI_B1) begin
      ai_region = 2'h0;
    end else if (r < `CTRC_AI_B2) begin
      ai_region = 2'h1;
    end else if (r < `CTRC_AI_B3) begin
      ai_region = 2'h2;
    end else begin
      ai_region = 2'h3;
    end
  endfunction

  // Region of an output update rate, half the input bounds
  function automatic ctrc_pkg::ctrc_region_type ao_region(input logic [RATE_W-1:0] r);
    if (r < `CTRC_AO_B1) begin
      ao_region = 2'h0;
    end else if (r < `CTRC_AO_B2) begin
      ao_region = 2'h1;
    end else if (r < `CTRC_AO_B3) begin
      ao_region = 2'h2;
    end else begin
      ao_region = 2'h3;
    end
  endfunction

  // Oversampling shift from input rate to timebase
  function automatic logic [4:0] tb_shift(input ctrc_pkg::ctrc_region_type g);
    case (g)
      2'h0: tb_shift = `CTRC_SH_R0;
      2'h1: tb_shift = `CTRC_SH_R1;
      default: tb_shift = `CTRC_SH_R23;
    endcase
  endfunction

  ctrc_pkg::ctrc_state_type state_q;
  ctrc_pkg::ctrc_region_type reg_q;
  ctrc_pkg::ctrc_region_type comp_reg_q;
  logic comp_valid_q;
  logic ai_cfg_q;
  logic ao_cfg_q;
  logic [31:0] comp_cnt_q;
  logic [7:0] ref_cnt_q;
  logic ref_prev_q;
  logic ref_alive_q;
  logic [1:0] boot_bank_q;
  ctrc_pkg::ctrc_region_type ai_g;
  ctrc_pkg::ctrc_region_type ao_g;
  logic locked;
  logic ai_ok;
  logic ao_ok;
  logic [31:0] comp_len;
  logic trig_ok;

  assign ai_g = ai_region(I_AI_RATE);
  assign ao_g = ao_region(I_AO_RATE);
  // Once the other running path holds a rate, only its region may be asked for
  assign locked = I_AI_EN && I_AO_EN;
  assign ai_ok = !(locked && ao_cfg_q && ai_g != reg_q);
  assign ao_ok = !(locked && ai_cfg_q && ao_g != reg_q);
  // A path that is enabled must be configured and already show its ready flag, and compensation must be done
  // Waiting for the flag costs one cycle but keeps a trigger from beating the ready that the host sees
  assign trig_ok = (I_AI_EN || I_AO_EN) && (!I_AI_EN || (ai_cfg_q && O_AI_READY))
                   && (!I_AO_EN || (ao_cfg_q && O_AO_READY)) && !O_COMP_BUSY;

  always_comb begin
    case (ai_g)
      2'h0: comp_len = COMP_CYC0;
      2'h1: comp_len = COMP_CYC1;
      2'h2: comp_len = COMP_CYC2;
      default: comp_len = COMP_CYC3;
    endcase
  end

  // Boot sequencing: fetch the stored bank choice after reset release
  always_ff @(posedge I_CLK) begin
    if (!I_RESET_N) begin
      state_q <= ctrc_pkg::CTRC_ST_BOOT;
      O_LOAD <= '0;
      boot_bank_q <= `CTRC_BANK_FACTORY;
    end else if (I_CE) begin
      O_LOAD.req <= 1'b0;
      case (state_q)
        ctrc_pkg::CTRC_ST_BOOT: begin
          state_q <= ctrc_pkg::CTRC_ST_LOAD;
        end
        ctrc_pkg::CTRC_ST_LOAD: begin
          // Without a valid user choice, factory constants are loaded
          if (I_NV_BOOT.req && (I_NV_BOOT.bank == `CTRC_BANK_USER1 ||
                                I_NV_BOOT.bank == `CTRC_BANK_USER2)) begin
            O_LOAD.bank <= I_NV_BOOT.bank;
            boot_bank_q <= I_NV_BOOT.bank;
          end else begin
            O_LOAD.bank <= `CTRC_BANK_FACTORY;
            boot_bank_q <= `CTRC_BANK_FACTORY;
          end
          O_LOAD.req <= 1'b1;
          state_q <= ctrc_pkg::CTRC_ST_RUN;
        end
        ctrc_pkg::CTRC_ST_RUN: begin
          state_q <= ctrc_pkg::CTRC_ST_RUN;
        end
        default: begin
          state_q <= ctrc_pkg::CTRC_ST_BOOT;
        end
      endcase
    end
  end

  // Boot bank assignment goes to nonvolatile storage; it takes effect at next boot
  always_ff @(posedge I_CLK) begin
    if (!I_RESET_N) begin
      O_NV_BOOT_WR <= '0;
    end else if (I_CE) begin
      O_NV_BOOT_WR.req <= I_BOOT_SET.req && (I_BOOT_SET.bank != 2'h3);
      O_NV_BOOT_WR.bank <= I_BOOT_SET.bank;
    end
  end

  // Auto-calibration results never reach the factory bank
  always_ff @(posedge I_CLK) begin
    if (!I_RESET_N) begin
      O_CAL_WR <= '0;
      O_CAL_REFUSED <= 1'b0;
    end else if (I_CE) begin
      O_CAL_WR.req <= I_CAL_STORE.req && (I_CAL_STORE.bank == `CTRC_BANK_USER1 ||
                                          I_CAL_STORE.bank == `CTRC_BANK_USER2);
      O_CAL_WR.bank <= I_CAL_STORE.bank;
      O_CAL_REFUSED <= I_CAL_STORE.req && (I_CAL_STORE.bank == `CTRC_BANK_FACTORY ||
                                           I_CAL_STORE.bank == 2'h3);
    end
  end

  // Path configuration and the shared region index
  always_ff @(posedge I_CLK) begin
    if (!I_RESET_N) begin
      ai_cfg_q <= 1'b0;
      ao_cfg_q <= 1'b0;
      reg_q <= 2'h0;
      O_CFG_REFUSED <= 1'b0;
      O_SYNTH_LOAD <= 1'b0;
    end else if (I_CE) begin
      O_CFG_REFUSED <= (I_AI_CFG_WR && !ai_ok) || (I_AO_CFG_WR && !ao_ok);
      O_SYNTH_LOAD <= 1'b0;
      // Input wins if both writes land together; the output write is then dropped unless it is refused
      if (I_AI_CFG_WR && ai_ok && state_q == ctrc_pkg::CTRC_ST_RUN) begin
        ai_cfg_q <= 1'b1;
        reg_q <= ai_g;
        O_SYNTH_LOAD <= 1'b1;
      end else if (!I_AI_EN) begin
        ai_cfg_q <= 1'b0;
      end
      if (I_AO_CFG_WR && ao_ok && !I_AI_CFG_WR && state_q == ctrc_pkg::CTRC_ST_RUN) begin
        ao_cfg_q <= 1'b1;
        reg_q <= ao_g;
        O_SYNTH_LOAD <= 1'b1;
      end else if (!I_AO_EN) begin
        ao_cfg_q <= 1'b0;
      end
    end
  end

  // One timebase for both converters, sized from an accepted input rate, else from any output write that passes ao_ok, even one that is dropped
  always_ff @(posedge I_CLK) begin
    if (!I_RESET_N) begin
      O_SYNTH_FREQ <= '0;
    end else if (I_CE && state_q == ctrc_pkg::CTRC_ST_RUN) begin
      if (I_AI_CFG_WR && ai_ok) begin
        O_SYNTH_FREQ <= FREQ_W'({6'h00, I_AI_RATE} << tb_shift(ai_g));
      end else if (I_AO_CFG_WR && ao_ok) begin
        O_SYNTH_FREQ <= FREQ_W'({6'h00, I_AO_RATE} << (tb_shift(ao_g) + 5'h01));
      end
    end
  end

  // Latency table follows the active region; region 3 output keeps the region 2 figure
  always_ff @(posedge I_CLK) begin
    if (!I_RESET_N) begin
      O_DELAY <= '0;
      O_REGION <= 2'h0;
    end else if (I_CE) begin
      O_REGION <= reg_q;
      case (reg_q)
        2'h0: O_DELAY <= '{`CTRC_AI_DLY_R0, `CTRC_AO_DLY_R0};
        2'h1: O_DELAY <= '{`CTRC_AI_DLY_R1, `CTRC_AO_DLY_R1};
        default: O_DELAY <= '{`CTRC_AI_DLY_R23, `CTRC_AO_DLY_R2};
      endcase
    end
  end

  // Offset compensation only on a change of input region
  always_ff @(posedge I_CLK) begin
    if (!I_RESET_N) begin
      comp_valid_q <= 1'b0;
      comp_reg_q <= 2'h0;
      comp_cnt_q <= '0;
      O_COMP_BUSY <= 1'b0;
    end else if (I_CE) begin
      if (I_AI_CFG_WR && ai_ok && state_q == ctrc_pkg::CTRC_ST_RUN &&
          (!comp_valid_q || ai_g != comp_reg_q)) begin
        comp_valid_q <= 1'b1;
        comp_reg_q <= ai_g;
        comp_cnt_q <= comp_len;
        O_COMP_BUSY <= 1'b1;
      end else if (comp_cnt_q > 32'h0000_0001) begin
        comp_cnt_q <= comp_cnt_q - 32'h0000_0001;
      end else begin
        comp_cnt_q <= '0;
        O_COMP_BUSY <= 1'b0;
      end
    end
  end

  // Trigger gate and ready flags
  always_ff @(posedge I_CLK) begin
    if (!I_RESET_N) begin
      O_TRIG_OUT <= 1'b0;
      O_TRIG_REFUSED <= 1'b0;
      O_AI_READY <= 1'b0;
      O_AO_READY <= 1'b0;
    end else if (I_CE) begin
      O_TRIG_OUT <= I_TRIG && trig_ok;
      O_TRIG_REFUSED <= I_TRIG && !trig_ok;
      O_AI_READY <= ai_cfg_q;
      O_AO_READY <= ao_cfg_q;
    end
  end

  // Reference activity watch; a stuck reference falls back to the local one
  always_ff @(posedge I_CLK) begin
    if (!I_RESET_N) begin
      ref_prev_q <= 1'b0;
      ref_cnt_q <= '0;
      ref_alive_q <= 1'b0;
      O_REF_EXT <= 1'b0;
    end else if (I_CE) begin
      ref_prev_q <= I_REF_10M;
      if (I_REF_10M != ref_prev_q) begin
        ref_cnt_q <= '0;
        ref_alive_q <= 1'b1;
      end else if (ref_cnt_q == 8'(`CTRC_REF_MISS)) begin
        ref_alive_q <= 1'b0;
      end else begin
        ref_cnt_q <= ref_cnt_q + 8'h01;
      end
      O_REF_EXT <= I_REF_EXT_EN && ref_alive_q;
    end
  end

endmodule // ctrc_top

// ---- tb/ctrc_asserts.sv ----
// Port checker for the timebase rate control block
`timescale 1ns/1ps
module ctrc_asserts #(
  parameter int FREQ_W = 25
) (
  input wire logic I_CLK, // Clock
  input wire logic I_RESET_N, // Reset, active low
  input wire logic I_REF_EXT_EN, // Reference request
  input wire logic I_AI_EN, // Input path on
  input wire logic I_AO_EN, // Output path on
  input wire logic I_TRIG, // Trigger
  input wire ctrc_pkg::ctrc_bank_cmd_type I_CAL_STORE, // Store request
  input wire ctrc_pkg::ctrc_bank_cmd_type I_BOOT_SET, // Boot bank set
  input wire ctrc_pkg::ctrc_bank_cmd_type I_NV_BOOT, // Stored choice
  input wire logic O_REF_EXT, // Reference in use
  input wire logic [FREQ_W-1:0] O_SYNTH_FREQ, // Timebase
  input wire logic O_SYNTH_LOAD, // Load pulse
  input wire ctrc_pkg::ctrc_region_type O_REGION, // Region
  input wire ctrc_pkg::ctrc_delay_type O_DELAY, // Latencies
  input wire logic O_AI_READY, // Input ready
  input wire logic O_AO_READY, // Output ready
  input wire logic O_CFG_REFUSED, // Rate refused
  input wire logic O_COMP_BUSY, // Compensating
  input wire logic O_TRIG_OUT, // Trigger out
  input wire logic O_TRIG_REFUSED, // Trigger refused
  input wire ctrc_pkg::ctrc_bank_cmd_type O_CAL_WR, // Bank write
  input wire logic O_CAL_REFUSED, // Bank write refused
  input wire ctrc_pkg::ctrc_bank_cmd_type O_NV_BOOT_WR, // Boot write
  input wire ctrc_pkg::ctrc_bank_cmd_type O_LOAD // Bank load
);
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (!I_RESET_N);
  // Shortest compensation count is five, so four cycles always hold
  sequence busy_hold; O_COMP_BUSY [*4]; endsequence
  sequence boot_load; ##[1:2] O_LOAD.req; endsequence
  AST_SYNTH_RANGE: assert property (O_SYNTH_LOAD |-> O_SYNTH_FREQ >= 512000 && O_SYNTH_FREQ <= 27648000) else $error("timebase out of range");
  AST_REFUSE_QUIET: assert property (O_CFG_REFUSED |-> !O_SYNTH_LOAD && $stable(O_SYNTH_FREQ)) else $error("refused rate applied");
  AST_TRIG_ANS: assert property (I_TRIG |=> O_TRIG_OUT != O_TRIG_REFUSED) else $error("trigger not answered once");
  AST_TRIG_GATE: assert property (O_TRIG_OUT |-> $past(!O_COMP_BUSY && (I_AI_EN || I_AO_EN) && (O_AI_READY || !I_AI_EN) && (O_AO_READY || !I_AO_EN))) else $error("trigger passed early");
  AST_AI_DELAY: assert property (O_AI_READY |-> O_DELAY.ai_samples == ((O_REGION == 2'h0) ? 4'hc : (O_REGION == 2'h1) ? 4'h7 : 4'h5)) else $error("input latency wrong");
  AST_CAL_STORE: assert property (I_CAL_STORE.req && I_CAL_STORE.bank inside {2'h1, 2'h2} |=> O_CAL_WR.req && O_CAL_WR.bank == $past(I_CAL_STORE.bank)) else $error("user bank store missing");
  AST_CAL_GUARD: assert property (I_CAL_STORE.req && !(I_CAL_STORE.bank inside {2'h1, 2'h2}) |=> O_CAL_REFUSED && !O_CAL_WR.req) else $error("guarded bank written");
  AST_BOOT_LOAD: assert property ($rose(I_RESET_N) |-> boot_load) else $error("no boot load");
  AST_BOOT_BANK: assert property (O_LOAD.req |-> O_LOAD.bank == ((I_NV_BOOT.req && I_NV_BOOT.bank inside {2'h1, 2'h2}) ? I_NV_BOOT.bank : 2'h0)) else $error("boot bank wrong");
  AST_NV_WR: assert property (I_BOOT_SET.req && I_BOOT_SET.bank != 2'h3 |=> O_NV_BOOT_WR.req && O_NV_BOOT_WR.bank == $past(I_BOOT_SET.bank)) else $error("boot choice not stored");
  AST_COMP_START: assert property ($rose(O_COMP_BUSY) |-> O_SYNTH_LOAD ##0 busy_hold) else $error("compensation start wrong");
  AST_REF_OFF: assert property (!I_REF_EXT_EN [*3] |-> !O_REF_EXT) else $error("reference used unasked");
endmodule // ctrc_asserts

// ---- tb/ctrc_far_side.sv ----
// Far-side model: backplane reference source and boot-choice storage
`timescale 1ns/1ps
module ctrc_far_side (
  input wire logic i_clk, // Block clock
  input wire logic i_ref_on, // Reference present
  input wire ctrc_pkg::ctrc_bank_cmd_type i_nv_wr, // Boot choice write
  output logic o_ref_10m, // Backplane reference
  output ctrc_pkg::ctrc_bank_cmd_type o_nv_boot // Stored choice, req means valid
);
  // Reference halts while absent, so loss detection gets exercised
  initial begin
    o_ref_10m = 1'h0;
    forever begin
      #50;
      if (i_ref_on) o_ref_10m = !o_ref_10m;
    end
  end
  // Storage starts blank and keeps its choice across block resets
  initial o_nv_boot = '0;
  always @(posedge i_clk) begin
    if (i_nv_wr.req === 1'h1) o_nv_boot <= i_nv_wr;
  end
endmodule // ctrc_far_side

// ---- tb/ctrc_top_bench.sv ----
// Self-checking bench for the timebase rate control block
`timescale 1ns/1ps
bind ctrc_top ctrc_asserts #(.FREQ_W(FREQ_W)) ctrc_asserts_inst (.*);
module ctrc_top_bench;
  logic I_CLK = 1'h0, I_RESET_N = 1'h0, I_CE = 1'h1, I_REF_EXT_EN = 1'h0, I_REF_10M, I_AI_EN = 1'h0, I_AO_EN = 1'h0;
  logic I_AI_CFG_WR = 1'h0, I_AO_CFG_WR = 1'h0, I_TRIG = 1'h0, O_REF_EXT, O_SYNTH_LOAD, O_AI_READY, O_AO_READY;
  logic O_CFG_REFUSED, O_COMP_BUSY, O_TRIG_OUT, O_TRIG_REFUSED, O_CAL_REFUSED, ref_on = 1'h0;
  logic [18:0] I_AI_RATE = 19'h0, I_AO_RATE = 19'h0;
  logic [24:0] O_SYNTH_FREQ;
  logic [2:0] last_g = 3'h4;
  ctrc_pkg::ctrc_bank_cmd_type I_CAL_STORE = '0, I_BOOT_SET = '0, I_NV_BOOT, O_CAL_WR, O_NV_BOOT_WR, O_LOAD;
  ctrc_pkg::ctrc_region_type O_REGION;
  ctrc_pkg::ctrc_delay_type O_DELAY;
  logic [31:0] exp_q[$];
  logic [18:0] rt[6] = '{19'h0bb80, 19'h0bb80, 19'h0d2f0, 19'h186a0, 19'h30d40, 19'h69780};
  int n_errors = 0, cmp_count = 0, cycles = 0, seed = 15884;
  // Short compensation counts keep the run brief
  ctrc_top #(.COMP_CYC0(32'h14), .COMP_CYC1(32'hf), .COMP_CYC2(32'ha), .COMP_CYC3(32'h5)) ctrc_top_inst (.*);
  ctrc_far_side ctrc_far_side_inst (.i_clk(I_CLK), .i_ref_on(ref_on), .i_nv_wr(O_NV_BOOT_WR), .o_ref_10m(I_REF_10M),
    .o_nv_boot(I_NV_BOOT));
  initial begin
    forever #2.5 I_CLK = !I_CLK;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict();
    $display("compares=%0d errors=%0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic take(input logic [31:0] s);
    logic [31:0] e;
    e = (exp_q.size() > 0) ? exp_q.pop_front() : 32'hffffffff;
    check(s, e);
  endtask
  // Inputs driven here always move 1 ns after the rising edge
  task automatic tick(input int n);
    repeat (n) @(posedge I_CLK);
    #1;
  endtask
  task automatic rate_wr(input logic ao, input logic [18:0] r, input logic [31:0] e);
    exp_q.push_back(e);
    I_AI_CFG_WR = !ao;
    I_AO_CFG_WR = ao;
    I_AI_RATE = r;
    I_AO_RATE = r;
    tick(1);
    I_AI_CFG_WR = 1'h0;
    I_AO_CFG_WR = 1'h0;
  endtask
  task automatic ai_case(input logic [18:0] r);
    logic [1:0] g;
    g = (r < 19'h0d2f0) ? 2'h0 : (r < 19'h1a5e0) ? 2'h1 : (r < 19'h34bc0) ? 2'h2 : 2'h3;
    rate_wr(1'h0, r, {4'h1, 3'h0, 25'(r) << ((g == 2'h0) ? 8 : (g == 2'h1) ? 7 : 6)});
    tick(1);
    check(O_COMP_BUSY, g != last_g);
    tick(1);
    check(O_REGION, g);
    check(O_DELAY.ai_samples, (g == 2'h0) ? 12 : (g == 2'h1) ? 7 : 5);
    check(O_DELAY.ao_tenths, (g == 2'h0) ? 434 : (g == 2'h1) ? 875 : 1768);
    last_g = g;
    tick(22);
  endtask
  task automatic trig(input logic [3:0] k);
    exp_q.push_back({k, 28'h0});
    I_TRIG = 1'h1;
    tick(1);
    I_TRIG = 1'h0;
    tick(2);
  endtask
  // Each result pulse takes the oldest expectation
  always @(negedge I_CLK) begin
    if (O_SYNTH_LOAD === 1'h1) take({4'h1, 3'h0, O_SYNTH_FREQ});
    if (O_CFG_REFUSED === 1'h1) take(32'h20000000);
    if (O_TRIG_OUT === 1'h1) take(32'h30000000);
    if (O_TRIG_REFUSED === 1'h1) take(32'h40000000);
    if (O_CAL_WR.req === 1'h1) take({4'h5, 26'h0, O_CAL_WR.bank});
    if (O_CAL_REFUSED === 1'h1) take(32'h60000000);
    if (O_NV_BOOT_WR.req === 1'h1) take({4'h7, 26'h0, O_NV_BOOT_WR.bank});
    if (O_LOAD.req === 1'h1) take({4'h8, 26'h0, O_LOAD.bank});
  end
  // A hang counts as a mismatch and still reaches the report
  always @(posedge I_CLK) begin
    cycles++;
    if (cycles == 4000) begin
      n_errors++;
      give_verdict();
    end
  end
  initial begin
    exp_q.push_back(32'h80000000);
    tick(5);
    I_RESET_N = 1'h1;
    tick(3);
    I_AI_EN = 1'h1;
    for (int i = 0; i < 10; i++) ai_case((i < 6) ? rt[i] : 19'(32'h7d0 + {$random(seed)} % 32'h68fb1));
    ai_case(19'h186a0);
    I_AO_EN = 1'h1;
    rate_wr(1'h1, 19'h09c40, {4'h1, 3'h0, 25'h09c4000});
    // Let an edge pass so the strobe is not raised in the step that lowered it
    tick(1);
    rate_wr(1'h1, 19'h04e20, 32'h20000000);
    tick(2);
    rate_wr(1'h0, 19'h0bb80, 32'h20000000);
    tick(2);
    trig(4'h3);
    I_AO_EN = 1'h0;
    tick(1);
    I_AO_EN = 1'h1;
    trig(4'h4);
    I_AI_EN = 1'h0;
    I_AO_EN = 1'h0;
    trig(4'h4);
    I_AI_EN = 1'h1;
    rate_wr(1'h0, 19'h69780, {4'h1, 3'h0, 25'h1a5e000});
    trig(4'h4);
    tick(10);
    trig(4'h3);
    for (int b = 0; b < 4; b++) begin
      exp_q.push_back((b == 1 || b == 2) ? {4'h5, 28'(b)} : 32'h60000000);
      I_CAL_STORE = {1'h1, 2'(b)};
      tick(1);
      I_CAL_STORE = '0;
      tick(1);
    end
    // Bank 3 is dropped silently, so only the second request answers
    I_BOOT_SET = {1'h1, 2'h3};
    tick(1);
    exp_q.push_back(32'h70000002);
    I_BOOT_SET = {1'h1, 2'h2};
    tick(1);
    I_BOOT_SET = '0;
    ref_on = 1'h1;
    I_REF_EXT_EN = 1'h1;
    tick(60);
    check(O_REF_EXT, 1);
    // Dropping the request must release the reference even while it is alive
    I_REF_EXT_EN = 1'h0;
    tick(3);
    check(O_REF_EXT, 0);
    I_REF_EXT_EN = 1'h1;
    tick(3);
    check(O_REF_EXT, 1);
    ref_on = 1'h0;
    tick(60);
    check(O_REF_EXT, 0);
    // With the clock enable low a rate write must leave every output frozen
    I_CE = 1'h0;
    I_AI_RATE = 19'(32'h7d0 + {$random(seed)} % 32'hcb20);
    I_AI_CFG_WR = 1'h1;
    tick(1);
    I_AI_CFG_WR = 1'h0;
    tick(2);
    check(O_REGION, 2'h3);
    check(O_SYNTH_FREQ, 25'h1a5e000);
    I_CE = 1'h1;
    tick(3);
    check(O_REGION, 2'h3);
    check(O_COMP_BUSY, 0);
    I_RESET_N = 1'h0;
    exp_q.push_back(32'h80000002);
    tick(5);
    I_RESET_N = 1'h1;
    tick(5);
    check(exp_q.size(), 0);
    give_verdict();
  end
endmodule // ctrc_top_bench
